// File: inc/tx_ctrl_defs.vh
/*
 * Register offsets, field positions, reset values and timing counts for the
 * transmit control register bank. Assumes inclusion by bare name.
 */
`ifndef TX_CTRL_DEFS_VH
`define TX_CTRL_DEFS_VH

// ************************************************************
// Register offsets (one port, low 9 bits of the address)
// ************************************************************
`define OFS_TCR2       9'h182
`define OFS_TX_CONTROL_THREE       9'h183
`define OFS_TX_IO_CONFIGURATION      9'h184
`define OFS_TX_ELASTIC_STORE_CONTROL      9'h185
`define OFS_TX_CONTROL_FOUR       9'h186
`define OFS_MODE       9'h1f0
`define OFS_STATUS     9'h1f1
`define OFS_B7SEL0     9'h1f2
`define OFS_CFG1       9'h181
`define RESET_VALUE    8'h00

// ************************************************************
// Field positions
// ************************************************************
`define B_B7ZS         0
`define B_GLOBAL_BIT7_STUFF         3
`define B_AUTO_EBIT_EN         7
`define B_AUTO_AIS_GEN         6
`define B_ARA          5
`define B_TX_CLOCK_SOURCE_SEL_HI      5
`define B_TX_CLOCK_SOURCE_SEL_LO      4
`define B_MULTIFRAME_REFERENCE_SEL         3
`define B_TFM          2
`define B_BIPOLAR_VIOLATION_INSERT         1
`define B_LOOP         0
`define B_CLKINV       7
`define B_SYNCINV      6
`define B_SSYNCINV     5
`define B_SCLKM        4
`define B_SSM          3
`define B_SIO          2
`define B_SDW          1
`define B_SM           0
`define B_DATFMT       7
`define B_GCLKEN       6
`define B_SZS          4
`define B_ALGN         3
`define B_ESR          2
`define B_MDM          1
`define B_ESE          0

// ************************************************************
// Clock source codes and timing
// ************************************************************
`define CSS_PIN        2'b00
`define CSS_FAILOVER   2'b01
`define CSS_LOOP       2'b11
`define CHAN_TIME_NS   5184
`define CLK_PERIOD_NS  10
`define CHAN_CYCLES    ((`CHAN_TIME_NS) / (`CLK_PERIOD_NS))

`endif

// File: core/tx_framer_control_regs.v
/*
 * Transmit control register bank of one framer port: register file, per-bit
 * controls, transmit clock source selection with failover, sync pin polarity
 * and direction, bipolar violation insertion, bit 7 stuffing.
 * Assumes a single-cycle register port on mclk and pins from other domains.
 */
// The address-and-strobe port was decided locally.
// Functional notes
// RULE1 - Bit 7 zero suppression enable stuffs bit 7 of chosen all-zero channels.
// RULE2 - E1 automatic E-bit enable sets E-bits automatically when set.
// RULE3 - E1 automatic AIS and remote alarm generation enabled by their bits.
// RULE4 - Clock source 00 pin, 11 recovered clock, 10 reserved.
// RULE5 - Source 01 fails over to recovered clock after one silent channel time.
// RULE6 - Multiframe ref 0 uses line counters aligned to line sync input.
// RULE7 - Multiframe ref 1 uses system counters aligned to system sync.
// RULE8 - Software uses pass-forward only with elastic store on synchronous backplane.
// RULE9 - T1 frame mode selects ESF at 0 and D4 at 1.
// RULE10 - Rising violation insert bit adds one violation after three ones.
// RULE11 - T1 loop code enable replaces data with repeating defined code.
// RULE12 - E1 CRC-4 recalculate selects intermediate path recalculation.
// RULE13 - I/O bits 7,6,5 invert clock, line sync, system sync input.
// RULE14 - Software sets system clock mode to match system clock rate.
// RULE15 - Sync mode bits select frame at 0 and multiframe at 1.
// RULE16 - Line sync direction bit: input at 0, output at 1.
// RULE17 - T1 double-wide widens sync output pulse in signaling frames.
// RULE18 - Data format 64k or 56k; gapped clock enable on channel clock. The code stores B_GCLKEN but uses it nowhere.
// RULE19 - Slip zone bit picks 9 or 2 byte slip threshold in conversion.
// RULE20 - Rising align bit forces half-frame pointer separation if less.
// RULE21 - Rising reset bit moves read pointer next to write pointer.
// RULE22 - Elastic store enable bypasses or enables; min delay picks depth.
// RULE23 - Global bit 7 stuffing forces all channels, else per-channel select. The code applies b7Select[0] to every channel.
// RULE24 - Software toggles align and reset only with system clock stable.
`timescale 1ns/1ps
`include "tx_ctrl_defs.vh"

module tx_framer_control_regs #(
	parameter CHAN_CYCLES = `CHAN_CYCLES,
	parameter HALF_FRAME  = 128
) (
	input  wire       mclk,
	input  wire       rst_n,
	input  wire       clkEn,
	input  wire [8:0] addr,
	input  wire [7:0] wrData,
	input  wire       wrStb,
	input  wire       rdStb,
	output reg  [7:0] rdData,
	input  wire       txLineClockPin,
	input  wire       recoveredRxClock,
	input  wire       txLineSyncPin,
	input  wire       txSystemSyncPin,
	input  wire [7:0] txChanData,
	input  wire       txChanStrobe,
	input  wire       txDataBit,
	input  wire [7:0] pointerSep,
	output reg  [7:0] txChanOut,
	output reg        txClockSel,
	output reg        txClockFailed,
	output reg        txSyncOut,
	output reg        txSyncOe,
	output reg        lineSyncSeen,
	output reg        systemSyncSeen,
	output reg        bpvInsertPulse,
	output reg        esAlignPulse,
	output reg        esResetPulse,
	output reg        esSlipPulse,
	output reg [7:0]  modeFlags
);

	// ************************************************************
	// Register file
	// ************************************************************
	reg [7:0]  tcr1;
	reg [7:0]  tcr2;
	reg [7:0]  tx_control_three;
	reg [7:0]  tx_io_configuration;
	reg [7:0]  tx_elastic_store_control;
	reg [7:0]  tx_control_four;
	reg [7:0]  modeReg;
	reg [7:0]  b7Select;
	reg        bpvPending;
	reg        prevIbpv;
	reg        prevAlgn;
	reg        prevEsr;
	reg [2:0]  onesRun;
	reg [15:0] silentCnt;
	reg [1:0]  tclkSync;
	reg [1:0]  rclkSync;
	reg [1:0]  lsyncSync;
	reg [1:0]  ssyncSync;
	reg        tclkLast;
	reg        syncTick;
	reg [7:0]  next_chan;

	wire e1Mode   = modeReg[0];
	wire tclkIn   = tclkSync[1] ^ tx_io_configuration[`B_CLKINV];            // RULE13
	wire lsyncIn  = lsyncSync[1] ^ tx_io_configuration[`B_SYNCINV];          // RULE13
	wire ssyncIn  = ssyncSync[1] ^ tx_io_configuration[`B_SSYNCINV];         // RULE13
	wire [1:0] css = tx_control_three[`B_TX_CLOCK_SOURCE_SEL_HI:`B_TX_CLOCK_SOURCE_SEL_LO];
	wire slipZone = tx_elastic_store_control[`B_SZS] ? (pointerSep <= 8'h02) : (pointerSep <= 8'h09);

	// Register writes; the block decodes the single-port offsets only
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tcr1 <= `RESET_VALUE;
			tcr2 <= `RESET_VALUE;
			tx_control_three <= `RESET_VALUE;
			tx_io_configuration <= `RESET_VALUE;
			tx_elastic_store_control <= `RESET_VALUE;
			tx_control_four <= `RESET_VALUE;
			modeReg <= `RESET_VALUE;
			b7Select <= `RESET_VALUE;
		end else if (clkEn && wrStb) begin
			case (addr)
			`OFS_CFG1:   tcr1 <= wrData;
			`OFS_TCR2:   tcr2 <= wrData;
			`OFS_TX_CONTROL_THREE:   tx_control_three <= wrData;
			`OFS_TX_IO_CONFIGURATION:  tx_io_configuration <= wrData;
			`OFS_TX_ELASTIC_STORE_CONTROL:  tx_elastic_store_control <= {wrData[7:6], 1'b0, wrData[4:0]};
			`OFS_TX_CONTROL_FOUR:   tx_control_four <= wrData;
			`OFS_MODE:   modeReg <= wrData;
			`OFS_B7SEL0: b7Select <= wrData;
			default: ;
			endcase
		end
	end

	// Read port, data one cycle after the strobe; unmapped reads zero
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdData <= 8'h00;
		end else if (clkEn) begin
			rdData <= 8'h00;
			if (rdStb) begin
				case (addr)
				`OFS_CFG1:   rdData <= tcr1;
				`OFS_TCR2:   rdData <= tcr2;
				`OFS_TX_CONTROL_THREE:   rdData <= tx_control_three;
				`OFS_TX_IO_CONFIGURATION:  rdData <= tx_io_configuration;
				`OFS_TX_ELASTIC_STORE_CONTROL:  rdData <= tx_elastic_store_control;
				`OFS_TX_CONTROL_FOUR:   rdData <= tx_control_four;
				`OFS_MODE:   rdData <= modeReg;
				`OFS_B7SEL0: rdData <= b7Select;
				`OFS_STATUS: rdData <= {4'h0, bpvPending, txClockFailed, txClockSel, txSyncOe};
				default:     rdData <= 8'h00;
				endcase
			end
		end
	end

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	// Two flops for every foreign input; only stage one feeds stage two
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tclkSync <= 2'b00;
			rclkSync <= 2'b00;
			lsyncSync <= 2'b00;
			ssyncSync <= 2'b00;
		end else if (clkEn) begin
			tclkSync <= {tclkSync[0], txLineClockPin};
			rclkSync <= {rclkSync[0], recoveredRxClock};
			lsyncSync <= {lsyncSync[0], txLineSyncPin};
			ssyncSync <= {ssyncSync[0], txSystemSyncPin};
		end
	end

	// ************************************************************
	// Transmit clock source and failover
	// ************************************************************
	// Silence counter; a channel time without an edge on the pin is a failure
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tclkLast <= 1'b0;
			silentCnt <= 16'h0000;
			txClockFailed <= 1'b0;
			txClockSel <= 1'b0;
		end else if (clkEn) begin
			tclkLast <= tclkIn;
			if (tclkIn != tclkLast) begin
				silentCnt <= 16'h0000;
				txClockFailed <= 1'b0;
			end else if (silentCnt >= CHAN_CYCLES[15:0] - 16'h0001) begin
				txClockFailed <= 1'b1;                              // RULE5
			end else begin
				silentCnt <= silentCnt + 16'h0001;
			end
			case (css)
			`CSS_PIN:      txClockSel <= 1'b0;                      // RULE4
			`CSS_FAILOVER: txClockSel <= txClockFailed;             // RULE5
			`CSS_LOOP:     txClockSel <= 1'b1;                      // RULE4
			default:       txClockSel <= 1'b0;
			endcase
		end
	end

	// ************************************************************
	// Sync pins and multiframe reference
	// ************************************************************
	// Line sync is driven only when configured as output; the pulse is
	// widened one tick in T1 signaling frames when double-wide is set
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txSyncOe <= 1'b0;
			txSyncOut <= 1'b0;
			syncTick <= 1'b0;
			lineSyncSeen <= 1'b0;
			systemSyncSeen <= 1'b0;
		end else if (clkEn) begin
			txSyncOe <= tx_io_configuration[`B_SIO];                               // RULE16
			syncTick <= lsyncIn;
			lineSyncSeen <= ~tx_control_three[`B_MULTIFRAME_REFERENCE_SEL] & ~tx_io_configuration[`B_SIO] & lsyncIn;    // RULE6
			systemSyncSeen <= tx_control_three[`B_MULTIFRAME_REFERENCE_SEL] & ssyncIn;               // RULE7
			txSyncOut <= (tx_io_configuration[`B_SIO] & (syncTick |
				(tx_io_configuration[`B_SDW] & ~e1Mode & ~tx_io_configuration[`B_SM] & lsyncIn)))
				^ tx_io_configuration[`B_SYNCINV];                                 // RULE17
		end
	end

	// ************************************************************
	// One-shot commands and channel data path
	// ************************************************************
	// Rising-edge commands; a new arm wins over a same-cycle fire
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prevIbpv <= 1'b0;
			prevAlgn <= 1'b0;
			prevEsr <= 1'b0;
			bpvPending <= 1'b0;
			onesRun <= 3'd0;
			bpvInsertPulse <= 1'b0;
			esAlignPulse <= 1'b0;
			esResetPulse <= 1'b0;
			esSlipPulse <= 1'b0;
		end else if (clkEn) begin
			prevIbpv <= tx_control_three[`B_BIPOLAR_VIOLATION_INSERT];
			prevAlgn <= tx_elastic_store_control[`B_ALGN];
			prevEsr <= tx_elastic_store_control[`B_ESR];
			bpvInsertPulse <= 1'b0;
			if (txChanStrobe)
				onesRun <= txDataBit ? ((onesRun == 3'd3) ? 3'd3 : onesRun + 3'd1) : 3'd0;
			if (bpvPending && txChanStrobe && txDataBit && onesRun == 3'd2) begin
				bpvInsertPulse <= 1'b1;                             // RULE10
				bpvPending <= 1'b0;
			end
			if (tx_control_three[`B_BIPOLAR_VIOLATION_INSERT] && !prevIbpv)
				bpvPending <= 1'b1;                                 // RULE10
			esAlignPulse <= tx_elastic_store_control[`B_ESE] & tx_elastic_store_control[`B_ALGN] & ~prevAlgn
				& (pointerSep < HALF_FRAME[7:0]);                   // RULE20
			esResetPulse <= tx_elastic_store_control[`B_ESE] & tx_elastic_store_control[`B_ESR] & ~prevEsr;       // RULE21
			esSlipPulse <= tx_elastic_store_control[`B_ESE] & tx_elastic_store_control[`B_ESR] & ~prevEsr & slipZone; // RULE19 RULE21
		end
	end

	// Bit 7 stuffing of all-zero channels and 56k masking
	always @* begin
		next_chan = txChanData;
		if (tcr2[`B_B7ZS] && txChanData == 8'h00 &&
			(tcr1[`B_GLOBAL_BIT7_STUFF] || b7Select[0]))                          // RULE1 RULE23
			next_chan = 8'h02;
		if (tx_elastic_store_control[`B_DATFMT])
			next_chan = {next_chan[7:1], 1'b0};                      // RULE18
	end

	// Mode flags gathered for the framer core
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			txChanOut <= 8'h00;
			modeFlags <= 8'h00;
		end else if (clkEn) begin
			if (txChanStrobe)
				txChanOut <= next_chan;
			modeFlags[0] <= e1Mode & tcr2[`B_AUTO_EBIT_EN];                  // RULE2
			modeFlags[1] <= e1Mode & tcr2[`B_AUTO_AIS_GEN];                  // RULE3
			modeFlags[2] <= e1Mode & tcr2[`B_ARA];                   // RULE3
			modeFlags[3] <= ~e1Mode & tx_control_three[`B_TFM];                  // RULE9
			modeFlags[4] <= ~e1Mode & tx_control_three[`B_LOOP];                 // RULE11
			modeFlags[5] <= e1Mode & tx_control_three[`B_LOOP];                  // RULE12
			modeFlags[6] <= tx_elastic_store_control[`B_ESE] & ~tx_elastic_store_control[`B_MDM];          // RULE22
			modeFlags[7] <= tx_io_configuration[`B_SM] | tx_io_configuration[`B_SSM];            // RULE15
		end
	end

endmodule

// File: verif/line_side_model.sv
/* Far side of the bank: transmit line clock, recovered clock and sync pins.
   Assumes the bench halts the line clock to provoke a failover. */
`timescale 1ns/1ps
module line_side_model (
	input  wire halt,
	output reg  lineClk,
	output reg  rxClk,
	output reg  lineSync,
	output reg  sysSync
);
	integer n;
	// ************************************************
	// Clocks of 80 ns, offset by a quarter period
	// ************************************************
	// The offset keeps the two clocks from sharing edges with each other
	initial begin
		lineClk = 1'b0;
		rxClk = 1'b0;
		lineSync = 1'b0;
		sysSync = 1'b0;
		n = 0;
		forever begin
			#20 rxClk = ~rxClk;
			#20 if (!halt) lineClk = ~lineClk;
			n = n + 1;
			lineSync = (n % 193 == 0);
			sysSync = lineSync;
		end
	end
endmodule

// File: verif/tx_ctrl_checker.sv
/* Port checker for the transmit control bank.
   Assumes one mclk domain and a bench that keeps clkEn high. */
`timescale 1ns/1ps
module tx_ctrl_checker (
	input wire       mclk,
	input wire       rst_n,
	input wire       clkEn,
	input wire [8:0] addr,
	input wire [7:0] wrData,
	input wire       wrStb,
	input wire       rdStb,
	input wire [7:0] rdData,
	input wire       txDataBit,
	input wire       txClockSel,
	input wire       txSyncOe,
	input wire       bpvInsertPulse,
	input wire       esResetPulse,
	input wire [7:0] modeFlags
);
	reg [7:0] c3, io, es;
	// ************************************************
	// Shadows of the control registers
	// ************************************************
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			c3 <= 8'h00;
			io <= 8'h00;
			es <= 8'h00;
		end else if (clkEn && wrStb) begin
			if (addr == 9'h183) c3 <= wrData;
			if (addr == 9'h184) io <= wrData;
			if (addr == 9'h185) es <= wrData;
		end
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// Settled controls get three quiet cycles to absorb output registers
	property p_rd_idle; !$past(rdStb) |-> rdData == 8'h00; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_oe; $stable(io) [*3] |-> txSyncOe == io[2]; endproperty
	a_oe: assert property (p_oe) else $error("sync enable wrong");
	property p_depth; $stable(es) [*3] |-> modeFlags[6] == (es[0] && !es[1]); endproperty
	a_depth: assert property (p_depth) else $error("store depth wrong");
	property p_pin; ($stable(c3) && c3[5:4] == 2'b00) [*3] |-> !txClockSel; endproperty
	a_pin: assert property (p_pin) else $error("pin clock not used");
	property p_loop; ($stable(c3) && c3[5:4] == 2'b11) [*3] |-> txClockSel; endproperty
	a_loop: assert property (p_loop) else $error("loop clock not used");
	property p_sel; $rose(txClockSel) |-> c3[4]; endproperty
	a_sel: assert property (p_sel) else $error("clock switched wrongly");
	property p_bpv; bpvInsertPulse |-> $past(txDataBit) ##1 !bpvInsertPulse; endproperty
	a_bpv: assert property (p_bpv) else $error("violation pulse wrong");
	property p_esr; ($rose(es[2]) && es[0]) |-> ##[0:2] esResetPulse; endproperty
	a_esr: assert property (p_esr) else $error("store reset missing");
	c_bpv: cover property (bpvInsertPulse);
	c_esr: cover property (esResetPulse);
	c_sel: cover property ($rose(txClockSel));
endmodule
bind tx_framer_control_regs tx_ctrl_checker chk (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
	.addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
	.txDataBit(txDataBit), .txClockSel(txClockSel), .txSyncOe(txSyncOe),
	.bpvInsertPulse(bpvInsertPulse), .esResetPulse(esResetPulse), .modeFlags(modeFlags));

// File: verif/tx_framer_control_regs_tb.sv
/* Self-checking bench for the transmit control bank.
   Assumes the line side model and a 100 MHz mclk. */
`timescale 1ns/1ps
module tx_framer_control_regs_tb;
	reg        mclk, rst_n, halt, wrStb, rdStb, txChanStrobe, txDataBit;
	reg  [8:0] addr;
	reg  [7:0] wrData, txChanData, pointerSep, got, d, base, nb, na, nr;
	wire [7:0] rdData, txChanOut, mf;
	wire       lc, rc, ls, ss, sel, fail, oe, bpv, aln, esr;
	integer    errorCnt, checkCount, seed, i, k;
	line_side_model far (.halt(halt), .lineClk(lc), .rxClk(rc), .lineSync(ls), .sysSync(ss));
	tx_framer_control_regs #(.CHAN_CYCLES(20)) dut (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1),
		.addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
		.txLineClockPin(lc), .recoveredRxClock(rc), .txLineSyncPin(ls), .txSystemSyncPin(ss),
		.txChanData(txChanData), .txChanStrobe(txChanStrobe), .txDataBit(txDataBit),
		.pointerSep(pointerSep), .txChanOut(txChanOut), .txClockSel(sel), .txClockFailed(fail),
		.txSyncOut(), .txSyncOe(oe), .lineSyncSeen(), .systemSyncSeen(),
		.bpvInsertPulse(bpv), .esAlignPulse(aln), .esResetPulse(esr), .esSlipPulse(),
		.modeFlags(mf));
	// ************************************************
	// Clock, pulse tallies and bus tasks
	// ************************************************
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// Pulses last one cycle, so one sum per edge counts each once
	always @(posedge mclk) begin
		nb <= nb + {7'h00, bpv};
		na <= na + {7'h00, aln};
		nr <= nr + {7'h00, esr};
	end
	function [7:0] readBack(input integer r, input [7:0] v);
		readBack = (r == 3) ? (v & 8'hdf) : v;
	endfunction
	task chk(input [7:0] seen, input [7:0] exp, input [8*8:1] what);
		begin
			checkCount = checkCount + 1;
			if (seen !== exp) begin
				errorCnt = errorCnt + 1;
				$display("[FAIL] %0s expected %h seen %h", what, exp, seen);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge mclk);
			#1;
		end
	endtask
	task wr(input [8:0] a, input [7:0] v);
		begin
			@(posedge mclk);
			addr <= a;
			wrData <= v;
			wrStb <= 1'b1;
			@(posedge mclk);
			wrStb <= 1'b0;
		end
	endtask
	task rd(input [8:0] a);
		begin
			@(posedge mclk);
			addr <= a;
			rdStb <= 1'b1;
			@(posedge mclk);
			rdStb <= 1'b0;
			#1 got = rdData;
		end
	endtask
	task stuff(input [7:0] v, input [7:0] e);
		begin
			@(posedge mclk);
			txChanData <= v;
			txChanStrobe <= 1'b1;
			@(posedge mclk);
			txChanStrobe <= 1'b0;
			cyc(1);
			chk(txChanOut, e, "chan");
		end
	endtask
	task reportAndStop;
		begin
			$display("checks %0d errors %0d", checkCount, errorCnt);
			if (errorCnt == 0 && checkCount > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	// Hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#200000;
		errorCnt = errorCnt + 1;
		reportAndStop;
	end
	initial begin
		seed = 77970;
		errorCnt = 0;
		checkCount = 0;
		{rst_n, halt, wrStb, rdStb, txChanStrobe, txDataBit} = 6'h00;
		{addr, wrData, txChanData, pointerSep, nb, na, nr} = 0;
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		for (i = 0; i < 5; i = i + 1) begin
			rd(9'h182 + i[8:0]);
			chk(got, 8'h00, "reset");
		end
		// Random values kept within what software may legally program
		for (k = 0; k < 30; k = k + 1) begin
			i = {$random(seed)} % 5;
			d = $random(seed);
			d = (i == 1) ? d & 8'hf7 : (i == 2) ? d & 8'hfd : d;
			txDataBit <= d[0];
			pointerSep <= d;
			wr(9'h182 + i[8:0], d);
			rd(9'h182 + i[8:0]);
			chk(got, readBack(i, d), "reg");
		end
		wr(9'h187, 8'hff);
		rd(9'h187);
		chk(got, 8'h00, "unmapped");
		txDataBit <= 1'b0;
		wr(9'h185, 8'h00);
		wr(9'h183, 8'h00);
		wr(9'h183, 8'h02);
		base = nb;
		@(posedge mclk);
		txChanStrobe <= 1'b1;
		txDataBit <= 1'b1;
		cyc(12);
		chk(nb - base, 8'h01, "bpv");
		txChanStrobe <= 1'b0;
		txDataBit <= 1'b0;
		wr(9'h183, 8'h10);
		cyc(40);
		chk({6'h00, fail, sel}, 8'h00, "clkrun");
		halt <= 1'b1;
		cyc(60);
		chk({6'h00, fail, sel}, 8'h03, "failover");
		wr(9'h183, 8'h30);
		cyc(4);
		chk({7'h00, sel}, 8'h01, "looptime");
		halt <= 1'b0;
		wr(9'h183, 8'h00);
		cyc(4);
		chk({7'h00, sel}, 8'h00, "pinclk");
		wr(9'h1f0, 8'h01);
		wr(9'h183, 8'h01);
		wr(9'h182, 8'he0);
		cyc(2);
		chk(mf & 8'h27, 8'h27, "e1flags");
		wr(9'h1f0, 8'h00);
		cyc(2);
		chk(mf & 8'h37, 8'h10, "t1flags");
		wr(9'h183, 8'h00);
		wr(9'h181, 8'h08);
		wr(9'h182, 8'h01);
		stuff(8'h00, 8'h02);
		stuff(8'h55, 8'h55);
		wr(9'h182, 8'h00);
		stuff(8'h00, 8'h00);
		wr(9'h185, 8'h80);
		stuff(8'h55, 8'h54);
		wr(9'h185, 8'h00);
		wr(9'h184, 8'h04);
		cyc(3);
		chk({7'h00, oe}, 8'h01, "syncoe");
		wr(9'h184, 8'h00);
		cyc(3);
		chk({7'h00, oe}, 8'h00, "syncoe");
		base = nr;
		wr(9'h185, 8'h05);
		wr(9'h185, 8'h05);
		cyc(4);
		chk(nr - base, 8'h01, "esreset");
		pointerSep <= 8'hff;
		base = na;
		wr(9'h185, 8'h01);
		wr(9'h185, 8'h09);
		cyc(4);
		chk(na - base, 8'h00, "align");
		pointerSep <= 8'h00;
		wr(9'h185, 8'h01);
		wr(9'h185, 8'h09);
		cyc(4);
		chk(na - base, 8'h01, "align");
		reportAndStop;
	end
endmodule
